// ===== line_cfg_pkg.sv
// Constants for the line and chip configuration register block
package line_cfg_pkg;
  localparam int         ADDR_W          = 7;
  localparam int         DATA_W          = 16;
  localparam logic [6:0] CFG_ADDR        = 7'h00;
  localparam logic [6:0] LINE_STAT_ADDR  = 7'h38;
  localparam logic [6:0] CTR_STAT_ADDR   = 7'h39;
  localparam int         BIT_STUFF       = 15;
  localparam int         BIT_LOOPBACK    = 14;
  localparam int         BIT_LATCH_CTR   = 13;
  localparam int         BIT_LATCH_LINE  = 12;
  localparam int         BIT_EXT_8K      = 11;
  localparam int         BIT_RCV_HOLD    = 10;
  localparam int         BIT_SCRAMBLE    = 9;
  localparam int         BIT_KEEP_VALID  = 8;
  localparam int         BIT_HEC_ALIGN   = 7;
  localparam int         BIT_PARALLEL    = 6;
  localparam int         BIT_EXT_FRAMER  = 5;
  localparam int         BIT_NO_LINECODE = 4;
  localparam int         BIT_UNFRAMED    = 3;
  localparam int         PHY_LSB         = 0;
  localparam int         VIOL_BIT        = 0;
  localparam logic [6:0] SPE_COLS_STUFF  = 7'h54;
  localparam logic [6:0] SPE_COLS_FULL   = 7'h56;
  localparam logic [2:0] PHY_DS3         = 3'h2;
  localparam logic [2:0] PHY_E3_751      = 3'h3;
  localparam int         SYNC_STAGES     = 3;
  localparam logic [2:0] SYNC_RESET      = 3'h0;
  localparam logic [15:0] WORD_ZERO      = 16'h0000;
endpackage

// ===== pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
  import line_cfg_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] level;
  logic [W-1:0] next_level;

  // Change counts only once the second and third stages agree
  always_comb begin
    next_level = level;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign o_level = level;
endmodule

// ===== line_chip_config_upper.sv
`timescale 1ns/1ps
module line_chip_config_upper
  import line_cfg_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [6:0]  i_addr,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata,
  input  wire logic [7:0]  i_tx_line_data,
  input  wire logic [7:0]  i_rx_line_data,
  output logic      [7:0]  o_rx_core_data,
  input  wire logic        i_one_second_tick_input,
  input  wire logic        i_receiver_hold_input,
  input  wire logic        i_ext_8k_ref,
  input  wire logic        i_rx_frame_ref,
  output logic             o_tx_frame_sync,
  input  wire logic        i_loss_of_delineation,
  input  wire logic [15:0] i_line_status,
  input  wire logic [15:0] i_ctr_status,
  output logic      [6:0]  o_spe_columns,
  output logic             o_source_loopback,
  output logic             o_hec_align,
  output logic      [2:0]  o_phy_type,
  output logic             o_unframed,
  output logic             o_no_line_code,
  output logic             o_ext_framer,
  output logic             o_parallel_if,
  output logic             o_scrambler_en,
  output logic             o_cell_accept,
  output logic             o_validate_en
);
  logic [15:0] cfg;
  logic [15:0] next_cfg;
  // Power-up state only; reset must not hide written settings
  logic        cfg_written = 1'b0;
  logic        next_cfg_written;
  logic [2:0]  pins;
  logic        tick_lvl;
  logic        hold_lvl;
  logic        ref8k_lvl;
  logic        tick_prev;
  logic        tick_rise;
  logic [15:0] eff_cfg;

  pin_sync #(
    .W (3)
  ) u_pin_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     ({i_ext_8k_ref, i_receiver_hold_input, i_one_second_tick_input}),
    .o_level   (pins)
  );
  assign tick_lvl  = pins[0];
  assign hold_lvl  = pins[1];
  assign ref8k_lvl = pins[2];
  assign tick_rise = tick_lvl & ~tick_prev;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] want);
    hit = (a == want);
  endfunction

  // Configuration storage, contents untouched by reset
  always_comb begin
    next_cfg         = cfg;
    next_cfg_written = cfg_written;
    if (i_wr_en && hit(i_addr, CFG_ADDR)) begin
      next_cfg         = i_wdata;
      next_cfg_written = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    cfg         <= next_cfg;
    cfg_written <= next_cfg_written;
  end

  // Controls decode as an all-zero word until software has written the word
  assign eff_cfg = cfg_written ? cfg : WORD_ZERO;

  // Per-word status latching, index 0 line status, index 1 counter status
  logic [15:0] cur_w     [2];
  logic [15:0] accum     [2];
  logic [15:0] held      [2];
  logic        read_once [2];
  logic [15:0] next_accum[2];
  logic [15:0] next_held [2];
  logic        next_read_once[2];
  logic [1:0]  latch_on;
  logic [1:0]  rd_hit;
  logic [15:0] rd_word   [2];

  assign cur_w[0]    = i_line_status;
  assign cur_w[1]    = i_ctr_status;
  assign latch_on[0] = eff_cfg[BIT_LATCH_LINE];
  assign latch_on[1] = eff_cfg[BIT_LATCH_CTR];
  assign rd_hit[0]   = i_rd_en && hit(i_addr, LINE_STAT_ADDR);
  assign rd_hit[1]   = i_rd_en && hit(i_addr, CTR_STAT_ADDR);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_word
      always_comb begin
        next_accum[g]     = accum[g] | cur_w[g];
        next_held[g]      = held[g];
        next_read_once[g] = read_once[g];
        rd_word[g]        = held[g];
        if (latch_on[g]) begin
          if (rd_hit[g]) begin
            if (read_once[g]) begin
              rd_word[g]    = cur_w[g];
              next_held[g]  = WORD_ZERO;
              next_accum[g] = cur_w[g];
            end else begin
              next_read_once[g] = 1'b1;
            end
          end
          if (tick_rise) begin
            next_held[g]      = accum[g] | cur_w[g];
            next_accum[g]     = cur_w[g];
            next_read_once[g] = 1'b0;
          end
        end else begin
          next_held[g]      = held[g] | cur_w[g];
          next_read_once[g] = 1'b0;
          if (rd_hit[g]) begin
            next_held[g] = cur_w[g];
          end
        end
        // Line code violation count bypasses latching
        if (g == 1) begin
          rd_word[g][VIOL_BIT] = cur_w[g][VIOL_BIT];
        end
      end

      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          accum[g]     <= WORD_ZERO;
          held[g]      <= WORD_ZERO;
          read_once[g] <= 1'b0;
        end else begin
          accum[g]     <= next_accum[g];
          held[g]      <= next_held[g];
          read_once[g] <= next_read_once[g];
        end
      end
    end
  endgenerate

  // Read data and decoded controls
  logic [15:0] next_rdata;
  logic [7:0]  next_rx_core;
  logic        next_tx_sync;
  logic        ext8k_active;
  logic        next_accept;
  logic        next_validate;

  assign ext8k_active = eff_cfg[BIT_EXT_8K] && !eff_cfg[BIT_HEC_ALIGN]
                        && (eff_cfg[2:0] == PHY_DS3 || eff_cfg[2:0] == PHY_E3_751);

  always_comb begin
    next_rdata = o_rdata;
    if (i_rd_en) begin
      if (hit(i_addr, CFG_ADDR)) begin
        next_rdata = eff_cfg;
      end else if (rd_hit[0]) begin
        next_rdata = rd_word[0];
      end else if (rd_hit[1]) begin
        next_rdata = rd_word[1];
      end else begin
        next_rdata = WORD_ZERO;
      end
    end
    next_rx_core  = eff_cfg[BIT_LOOPBACK] ? i_tx_line_data : i_rx_line_data;
    next_tx_sync  = ext8k_active ? ref8k_lvl : i_rx_frame_ref;
    next_accept   = !(eff_cfg[BIT_RCV_HOLD] && hold_lvl);
    next_validate = eff_cfg[BIT_KEEP_VALID] || !i_loss_of_delineation;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_prev       <= 1'b0;
      o_rdata         <= WORD_ZERO;
      o_rx_core_data  <= 8'h00;
      o_tx_frame_sync <= 1'b0;
      o_cell_accept   <= 1'b1;
      o_validate_en   <= 1'b0;
    end else begin
      tick_prev       <= tick_lvl;
      o_rdata         <= next_rdata;
      o_rx_core_data  <= next_rx_core;
      o_tx_frame_sync <= next_tx_sync;
      o_cell_accept   <= next_accept;
      o_validate_en   <= next_validate;
    end
  end

  assign o_spe_columns     = eff_cfg[BIT_STUFF] ? SPE_COLS_STUFF : SPE_COLS_FULL;
  assign o_source_loopback = eff_cfg[BIT_LOOPBACK];
  assign o_hec_align       = eff_cfg[BIT_HEC_ALIGN];
  assign o_phy_type        = eff_cfg[PHY_LSB +: 3];
  assign o_unframed        = eff_cfg[BIT_UNFRAMED];
  assign o_no_line_code    = eff_cfg[BIT_NO_LINECODE];
  assign o_ext_framer      = eff_cfg[BIT_EXT_FRAMER];
  assign o_parallel_if     = eff_cfg[BIT_PARALLEL];
  assign o_scrambler_en    = eff_cfg[BIT_SCRAMBLE];

  chk_cfg_readback: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_wr_en && i_addr == CFG_ADDR) ##1 !i_wr_en ##1 (i_rd_en && i_addr == CFG_ADDR && !i_wr_en)
    |=> o_rdata == $past(i_wdata, 3))
    else $error("config readback differs from written value");
  chk_spe_cols: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cfg_written |-> o_spe_columns == (cfg[BIT_STUFF] ? 7'h54 : 7'h56))
    else $error("payload column count wrong");
  chk_loop_path: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (cfg_written && cfg[BIT_LOOPBACK]) |=> o_rx_core_data == $past(i_tx_line_data))
    else $error("loopback not feeding receiver");
  chk_hold_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (cfg_written && cfg[BIT_RCV_HOLD] && hold_lvl) |=> !o_cell_accept)
    else $error("cells accepted during hold");
  chk_valid_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (cfg_written && cfg[BIT_KEEP_VALID]) |=> o_validate_en)
    else $error("validation stopped despite keep bit");
  chk_ext8k_sel: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (cfg_written && cfg[BIT_HEC_ALIGN]) |=> o_tx_frame_sync == $past(i_rx_frame_ref))
    else $error("external 8k used outside 57-octet mode");
  chk_tick_latch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (latch_on[0] && tick_rise && !rd_hit[0]) |=> held[0] == $past(accum[0] | i_line_status))
    else $error("line status not latched at tick");
  chk_second_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (latch_on[0] && rd_hit[0] && read_once[0] && !tick_rise && !i_wr_en)
    |=> o_rdata == $past(i_line_status) && held[0] == 16'h0000)
    else $error("second read not current or not cleared");
  chk_viol_live: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (rd_hit[1] && !rd_hit[0] && i_addr != CFG_ADDR) |=> o_rdata[0] == $past(i_ctr_status[0]))
    else $error("violation count bit was latched");
endmodule

// ===== host_bus_model.sv
// Host processor model driving the parallel register bus
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  output logic      [6:0]  o_addr,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic      [15:0] o_wdata
);
  initial begin
    o_addr  = 7'h00;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_wdata = 16'h0000;
  end

  // Host sets every word itself; loopback never paired with parallel mode
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_wdata = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_rd_en = 1'b1;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    d       = i_rdata;
  endtask
endmodule

// ===== line_chip_config_upper_tb.sv
// Self-checking bench for the line and chip configuration block
`timescale 1ns/1ps
module line_chip_config_upper_tb;
  import line_cfg_pkg::*;
  typedef struct {
    logic [15:0] w;
    logic [6:0]  cols;
    logic [6:0]  fl;
    logic [2:0]  phy;
  } row_t;
  logic        i_clk, i_sys_rst, wr_en, rd_en, tick, hold, ext, fref, loss;
  logic [6:0]  addr, cols;
  logic [15:0] wdata, rdata, lstat, cstat, d;
  logic [7:0]  tx, rx, core;
  logic        sync, lb, hec, unf, nlc, xfr, par, scr, acc, val;
  logic [2:0]  phy;
  int          failures, total_checks, cycles;
  row_t        rows [3];

  host_bus_model i_host_bus_model (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_wdata(wdata));

  line_chip_config_upper i_line_chip_config_upper (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(addr), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_wdata(wdata), .o_rdata(rdata),
    .i_tx_line_data(tx), .i_rx_line_data(rx), .o_rx_core_data(core),
    .i_one_second_tick_input(tick), .i_receiver_hold_input(hold), .i_ext_8k_ref(ext),
    .i_rx_frame_ref(fref), .o_tx_frame_sync(sync), .i_loss_of_delineation(loss),
    .i_line_status(lstat), .i_ctr_status(cstat), .o_spe_columns(cols),
    .o_source_loopback(lb), .o_hec_align(hec), .o_phy_type(phy), .o_unframed(unf),
    .o_no_line_code(nlc), .o_ext_framer(xfr), .o_parallel_if(par),
    .o_scrambler_en(scr), .o_cell_accept(acc), .o_validate_en(val));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end

  task automatic wr(input logic [15:0] v);
    i_host_bus_model.wr(CFG_ADDR, v);
  endtask

  task automatic gap(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  initial begin
    rows[0] = '{16'h8000, 7'h54, 7'h00, 3'h0};
    rows[1] = '{16'h4200, 7'h56, 7'h50, 3'h0};
    rows[2] = '{16'h00FF, 7'h56, 7'h2F, 3'h7};
    {i_sys_rst, tick, hold, ext, fref, loss} = 6'h20;
    {tx, rx, lstat, cstat} = 48'h0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    i_host_bus_model.rd(CFG_ADDR, d);
    check(d, 16'h0000);
    foreach (rows[k]) begin
      wr(rows[k].w);
      check({9'h000, cols}, {9'h000, rows[k].cols});
      check({9'h000, lb, hec, scr, xfr, unf, nlc, par}, {9'h000, rows[k].fl});
      check({13'h0000, phy}, {13'h0000, rows[k].phy});
      i_host_bus_model.rd(CFG_ADDR, d);
      check(d, rows[k].w);
    end
    i_host_bus_model.rd(7'h05, d);
    check(d, 16'h0000);
    wr(16'h4000);
    tx = 8'hA5;
    rx = 8'h3C;
    gap(2);
    check({8'h00, core}, 16'h00A5);
    wr(16'h4022);
    fref = 1'b1;
    gap(2);
    check({8'h00, core}, 16'h00A5);
    check({15'h0000, sync}, 16'h0001);
    fref = 1'b0;
    wr(16'h0000);
    gap(2);
    check({8'h00, core}, 16'h003C);
    wr(16'h0400);
    hold = 1'b1;
    gap(8);
    check({15'h0000, acc}, 16'h0000);
    wr(16'h0000);
    gap(2);
    check({15'h0000, acc}, 16'h0001);
    loss = 1'b1;
    wr(16'h0100);
    gap(2);
    check({15'h0000, val}, 16'h0001);
    wr(16'h0000);
    gap(2);
    check({15'h0000, val}, 16'h0000);
    wr(16'h0802);
    ext = 1'b1;
    gap(8);
    check({15'h0000, sync}, 16'h0001);
    wr(16'h0803);
    gap(2);
    check({15'h0000, sync}, 16'h0001);
    wr(16'h0883);
    gap(2);
    check({15'h0000, sync}, 16'h0000);
    wr(16'h0002);
    gap(2);
    check({15'h0000, sync}, 16'h0000);
    wr(16'h1000);
    lstat = 16'h0005;
    gap(2);
    lstat = 16'h0000;
    tick = 1'b1;
    gap(10);
    i_host_bus_model.rd(LINE_STAT_ADDR, d);
    check(d, 16'h0005);
    i_host_bus_model.rd(LINE_STAT_ADDR, d);
    check(d, 16'h0000);
    tick = 1'b0;
    gap(8);
    wr(16'h2000);
    cstat = 16'h0003;
    gap(2);
    cstat = 16'h0000;
    tick = 1'b1;
    gap(10);
    i_host_bus_model.rd(CTR_STAT_ADDR, d);
    check(d, 16'h0002);
    wr(16'hC200);
    i_sys_rst = 1'b1;
    gap(2);
    i_sys_rst = 1'b0;
    check({9'h000, cols}, {9'h000, SPE_COLS_STUFF});
    i_host_bus_model.rd(CFG_ADDR, d);
    check(d, 16'hC200);
    test_done();
  end
endmodule
